// ==== cmdctl_cfg.svh ====
// offsets, field positions, reset values and timing counts of the command block
`ifndef CMDCTL_CFG_SVH
`define CMDCTL_CFG_SVH

// ********************************
// register map
// ********************************
`define ADDR_W            6
`define DATA_W            8
`define RESERVED_ZERO_OFS 6'h00
`define COMMAND_CTRL_OFS  6'h01
`define RESERVED_ZERO_RST 8'h00
`define COMMAND_CTRL_RST  8'h20

// ********************************
// command_control field layout
// ********************************
`define RSVD_HI_BIT       7
`define RSVD_LO_BIT       6
`define RCV_OFF_BIT       5
`define SLEEP_BIT         4
`define CMD_HI_BIT        3
`define CMD_LO_BIT        0
`define CMD_W             4

// ********************************
// command codes
// ********************************
`define CMD_IDLE          4'h0
`define CMD_SOFT_REINIT   4'hF
// bit n set: code n is a known command
`define CMD_KNOWN_MASK    16'h81FF

// ********************************
// timing
// ********************************
`define CLK_PERIOD_NS     10
`define WAKE_TIME_NS      1000
`define WAKE_CYCLES       ((`WAKE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WAKE_CNT_W        12

`endif

// ==== cmdctl_pkg.sv ====
// types shared by the command and power control block
`default_nettype none
package cmdctl_pkg;

    // ********************************
    // power state, one-hot
    // ********************************
    typedef enum logic [2:0] {
        PWR_AWAKE  = 3'b001,
        PWR_SLEEP  = 3'b010,
        PWR_WAKING = 3'b100
    } pwr_state_e;

    // ********************************
    // register access request
    // ********************************
    typedef struct packed {
        logic       wr_en;
        logic       rd_en;
        logic [5:0] addr;
        logic [7:0] wdata;
    } reg_req_s;

endpackage
`default_nettype wire

// ==== wake_timer.sv ====
// down-counter timing the wake-up sequence
`timescale 1ns/1ns
`default_nettype none
`include "cmdctl_cfg.svh"

module wake_timer (
    // clock and reset
    input  wire logic mclk,
    input  wire logic sys_rst,
    // control
    input  wire logic start,
    // status
    output logic      busy,
    output logic      done
);

    logic [`WAKE_CNT_W-1:0] cnt_ff;
    logic [`WAKE_CNT_W-1:0] nxt_cnt;
    logic                   done_ff;
    logic                   nxt_done;

    // ********************************
    // count logic
    // ********************************
    // a restart while busy reloads the full count
    always_comb begin
        nxt_cnt  = cnt_ff;
        nxt_done = 1'b0;
        if (start) begin
            nxt_cnt = `WAKE_CNT_W'(`WAKE_CYCLES);
        end else if (cnt_ff != '0) begin
            nxt_cnt = cnt_ff - `WAKE_CNT_W'(1);
            if (cnt_ff == `WAKE_CNT_W'(1)) begin
                nxt_done = 1'b1;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            cnt_ff  <= '0;
            done_ff <= 1'b0;
        end else begin
            cnt_ff  <= nxt_cnt;
            done_ff <= nxt_done;
        end
    end

    assign busy = (cnt_ff != '0);
    assign done = done_ff;

endmodule
`default_nettype wire

// ==== cmdctl.sv ====
// command and power control register with the reserved register at zero
//
// Operation
// - command_control at 0x01, resets to 0x20
// - register 0x00 reserved, reads zero
// - bit 5 set switches receiver analog off
// - writing one to bit 4 while awake enters sleep
// - writing zero wakes; bit reads one meanwhile
// - bit reads zero once wake-up finishes
// - sleep refused while software reinit runs
// - writing bits 3:0 starts that command
// - command field reads the running command
// - finished command returns idle, sets flag
// - unknown code returns idle, sets flag
// - host writing idle sets no flag
`timescale 1ns/1ns
`default_nettype none
`include "cmdctl_cfg.svh"

module cmdctl (
    // clock and reset
    input  wire logic               mclk,
    input  wire logic               sys_rst,
    // register port
    input  wire cmdctl_pkg::reg_req_s reg_req,
    output logic [`DATA_W-1:0]      reg_rdata,
    // command engine
    output logic [`CMD_W-1:0]       cmd_code,
    output logic                    cmd_start,
    input  wire logic               cmd_finish,
    // done flag, cleared by its status register
    input  wire logic               done_flag_clr,
    output logic                    operation_done_flag,
    // analog and power control
    output logic                    receiver_analog_disable,
    output logic                    sleep_active
);

    // ********************************
    // state
    // ********************************
    cmdctl_pkg::pwr_state_e pwr_ff;
    cmdctl_pkg::pwr_state_e nxt_pwr;
    logic [`CMD_W-1:0]      cmd_ff;
    logic [`CMD_W-1:0]      nxt_cmd;
    logic                   rcv_off_ff;
    logic                   nxt_rcv_off;
    logic                   flag_ff;
    logic                   nxt_flag;
    logic                   start_ff;
    logic                   nxt_start;
    logic [`DATA_W-1:0]     rdata_ff;
    logic [`DATA_W-1:0]     nxt_rdata;
    logic                   wake_start;
    logic                   wake_busy;
    logic                   wake_done;

    // ********************************
    // decoded access
    // ********************************
    logic                   wr_cmd;
    logic [`CMD_W-1:0]      wr_code;
    logic                   wr_sleep;
    logic                   code_known;
    logic                   reinit_active;
    logic                   sleep_bit;
    logic [`DATA_W-1:0]     cmd_view;

    assign wr_cmd   = reg_req.wr_en && (reg_req.addr == `COMMAND_CTRL_OFS);
    assign wr_code  = reg_req.wdata[`CMD_HI_BIT:`CMD_LO_BIT];
    assign wr_sleep = reg_req.wdata[`SLEEP_BIT];
    assign code_known    = 1'(`CMD_KNOWN_MASK >> wr_code);
    assign reinit_active = (cmd_ff == `CMD_SOFT_REINIT);
    // waking still shows as asleep so software can poll
    assign sleep_bit = (pwr_ff != cmdctl_pkg::PWR_AWAKE);

    // reserved bits are forced to zero on read
    always_comb begin
        cmd_view                            = '0;
        cmd_view[`RCV_OFF_BIT]              = rcv_off_ff;
        cmd_view[`SLEEP_BIT]                = sleep_bit;
        cmd_view[`CMD_HI_BIT:`CMD_LO_BIT]   = cmd_ff;
    end

    // ********************************
    // command field and done flag
    // ********************************
    // a host write beats a finish arriving in the same cycle
    always_comb begin
        nxt_cmd   = cmd_ff;
        nxt_flag  = flag_ff;
        nxt_start = 1'b0;
        if (done_flag_clr) begin
            nxt_flag = 1'b0;
        end
        if (cmd_finish && (cmd_ff != `CMD_IDLE)) begin
            nxt_cmd  = `CMD_IDLE;
            nxt_flag = 1'b1;
        end
        if (wr_cmd) begin
            if (wr_code == `CMD_IDLE) begin
                nxt_cmd = `CMD_IDLE;
            end else if (!code_known) begin
                nxt_cmd  = `CMD_IDLE;
                nxt_flag = 1'b1;
            end else begin
                nxt_cmd   = wr_code;
                nxt_start = 1'b1;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            cmd_ff   <= `CMD_IDLE;
            flag_ff  <= 1'b0;
            start_ff <= 1'b0;
        end else begin
            cmd_ff   <= nxt_cmd;
            flag_ff  <= nxt_flag;
            start_ff <= nxt_start;
        end
    end

    // ********************************
    // receiver analog switch
    // ********************************
    always_comb begin
        nxt_rcv_off = rcv_off_ff;
        if (wr_cmd) begin
            nxt_rcv_off = reg_req.wdata[`RCV_OFF_BIT];
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            rcv_off_ff <= 1'(`COMMAND_CTRL_RST >> `RCV_OFF_BIT);
        end else begin
            rcv_off_ff <= nxt_rcv_off;
        end
    end

    // ********************************
    // soft power-down
    // ********************************
    // sleep is refused while reinit runs; the write of that code in the
    // same cycle also counts, so a combined write cannot sneak through
    always_comb begin
        nxt_pwr    = pwr_ff;
        wake_start = 1'b0;
        unique case (pwr_ff)
            cmdctl_pkg::PWR_AWAKE: begin
                if (wr_cmd && wr_sleep && !reinit_active
                    && !(wr_code == `CMD_SOFT_REINIT)) begin
                    nxt_pwr = cmdctl_pkg::PWR_SLEEP;
                end
            end
            cmdctl_pkg::PWR_SLEEP: begin
                if (wr_cmd && !wr_sleep) begin
                    nxt_pwr    = cmdctl_pkg::PWR_WAKING;
                    wake_start = 1'b1;
                end
            end
            cmdctl_pkg::PWR_WAKING: begin
                if (wake_done) begin
                    nxt_pwr = cmdctl_pkg::PWR_AWAKE;
                end
            end
            default: begin
                nxt_pwr = cmdctl_pkg::PWR_AWAKE;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            pwr_ff <= cmdctl_pkg::PWR_AWAKE;
        end else begin
            pwr_ff <= nxt_pwr;
        end
    end

    wake_timer u_wake (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .start   (wake_start),
        .busy    (wake_busy),
        .done    (wake_done)
    );

    // ********************************
    // read data
    // ********************************
    // data lands one cycle after the read strobe and then holds
    always_comb begin
        nxt_rdata = rdata_ff;
        if (reg_req.rd_en) begin
            unique case (reg_req.addr)
                `RESERVED_ZERO_OFS: nxt_rdata = `RESERVED_ZERO_RST;
                `COMMAND_CTRL_OFS:  nxt_rdata = cmd_view;
                default:            nxt_rdata = '0;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            rdata_ff <= '0;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    // ********************************
    // outputs
    // ********************************
    assign reg_rdata               = rdata_ff;
    assign cmd_code                = cmd_ff;
    assign cmd_start               = start_ff;
    assign operation_done_flag     = flag_ff;
    assign receiver_analog_disable = rcv_off_ff;
    assign sleep_active            = (pwr_ff == cmdctl_pkg::PWR_SLEEP);

    // ********************************
    // assertions
    // ********************************
    localparam int WAKE_LIM = `WAKE_CYCLES + 2;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    sequence sleep_then_wake;
        sleep_active ##1 (wr_cmd && !wr_sleep);
    endsequence

    sequence wake_runs;
        (sleep_bit && !sleep_active)[*2];
    endsequence

    reset_value_a: assert property (@(posedge mclk) disable iff (1'b0)
        $past(sys_rst) |-> cmd_view == `COMMAND_CTRL_RST)
        else $error("command register reset value wrong");

    reserved_read_a: assert property (
        reg_req.rd_en && reg_req.addr == `RESERVED_ZERO_OFS
        |=> reg_rdata == 8'h00)
        else $error("reserved register read non-zero");

    rcv_off_a: assert property (
        wr_cmd |=> receiver_analog_disable == $past(reg_req.wdata[5]))
        else $error("receiver switch not as written");

    sleep_enter_a: assert property (
        pwr_ff == cmdctl_pkg::PWR_AWAKE && wr_cmd && wr_sleep
        && cmd_ff == `CMD_IDLE && wr_code == `CMD_IDLE
        |=> sleep_active && sleep_bit)
        else $error("sleep not entered");

    wake_busy_a: assert property (
        sleep_then_wake |=> wake_runs)
        else $error("sleep bit dropped early in wake-up");

    wake_done_a: assert property (
        sleep_then_wake |-> ##[1:WAKE_LIM] !sleep_bit)
        else $error("wake-up did not complete in time");

    reinit_block_a: assert property (
        !sleep_bit && wr_cmd && reinit_active |=> !sleep_bit)
        else $error("sleep taken during software reinit");

    cmd_run_a: assert property (
        wr_cmd && wr_code != `CMD_IDLE && code_known
        |=> cmd_start && cmd_code == $past(wr_code))
        else $error("command not started");

    cmd_finish_a: assert property (
        cmd_finish && cmd_ff != `CMD_IDLE && !wr_cmd
        |=> cmd_code == `CMD_IDLE && operation_done_flag)
        else $error("finish did not return to idle");

    unknown_a: assert property (
        wr_cmd && !code_known |=> cmd_code == `CMD_IDLE && operation_done_flag)
        else $error("unknown code not rejected");

    idle_write_a: assert property (
        wr_cmd && wr_code == `CMD_IDLE && !cmd_finish && !flag_ff
        |=> !operation_done_flag)
        else $error("host idle write raised flag");

    rsvd_bits_a: assert property (
        reg_req.rd_en && reg_req.addr == `COMMAND_CTRL_OFS
        |=> reg_rdata[7:6] == 2'b00)
        else $error("reserved bits read non-zero");

    // waking must always be backed by a running or just-ended timer
    wake_track_a: assert property (
        pwr_ff == cmdctl_pkg::PWR_WAKING |-> wake_busy || wake_done)
        else $error("waking without a running wake timer");

    // a finish in the cycle of a flag clear must leave the flag set
    flag_set_a: assert property (
        cmd_finish && cmd_ff != `CMD_IDLE && done_flag_clr
        |=> operation_done_flag)
        else $error("flag clear beat a finish");

endmodule
`default_nettype wire

// ==== command_power_control_register_tb.sv ====
// self-checking bench of the command and power control block
`timescale 1ns/1ns
`default_nettype none
`include "cmdctl_cfg.svh"

module command_power_control_register_tb;

    logic                 mclk;
    logic                 sys_rst;
    cmdctl_pkg::reg_req_s req;
    logic [7:0]           rdata;
    logic [3:0]           cmd_code;
    logic                 cmd_start;
    logic                 cmd_finish;
    logic                 done_flag_clr;
    logic                 done_flag;
    logic                 rx_off;
    logic                 sleep_active;
    int                   errors;
    int                   tests_run;
    logic [31:0]          seed;
    logic [7:0]           got;
    logic [15:0]          known;

    cmdctl DUT (
        .mclk                    (mclk),
        .sys_rst                 (sys_rst),
        .reg_req                 (req),
        .reg_rdata               (rdata),
        .cmd_code                (cmd_code),
        .cmd_start               (cmd_start),
        .cmd_finish              (cmd_finish),
        .done_flag_clr           (done_flag_clr),
        .operation_done_flag     (done_flag),
        .receiver_analog_disable (rx_off),
        .sleep_active            (sleep_active)
    );

    // ********************************
    // helpers
    // ********************************
    function automatic logic [31:0] next_rand();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // expected command field after writing a code
    function automatic logic [3:0] exp_code(input int c);
        logic [15:0] mask;
        mask = `CMD_KNOWN_MASK;
        return (mask[c] && c != 0) ? 4'(c) : 4'h0;
    endfunction

    task automatic chk(input string what, input logic [7:0] exp,
                       input logic [7:0] act);
        tests_run++;
        if (act !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, act);
        end
    endtask

    // one-cycle write strobe; results settle 1 ns after the taking edge
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge mclk);
        req <= '{wr_en: 1'b1, rd_en: 1'b0, addr: a, wdata: d};
        @(posedge mclk);
        req.wr_en <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [5:0] a);
        @(posedge mclk);
        req <= '{wr_en: 1'b0, rd_en: 1'b1, addr: a, wdata: 8'h00};
        @(posedge mclk);
        req.rd_en <= 1'b0;
        #1;
        got = rdata;
    endtask

    task automatic fin();
        @(posedge mclk);
        cmd_finish <= 1'b1;
        @(posedge mclk);
        cmd_finish <= 1'b0;
        #1;
    endtask

    task automatic clr();
        @(posedge mclk);
        done_flag_clr <= 1'b1;
        @(posedge mclk);
        done_flag_clr <= 1'b0;
        #1;
    endtask

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // ********************************
    // clock and watchdog
    // ********************************
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // a hang is cut short and counted as a mismatch
    initial begin
        repeat (20000) @(posedge mclk);
        errors++;
        end_sim();
    end

    // main sequence
    initial begin
        logic [7:0] d;
        logic [3:0] ec;
        int         n;
        sys_rst = 1'b1;
        req = '0;
        cmd_finish = 1'b0;
        done_flag_clr = 1'b0;
        seed = 32'h0244;
        errors = 0;
        tests_run = 0;
        known = `CMD_KNOWN_MASK;
        repeat (10) @(posedge mclk);
        sys_rst <= 1'b0;
        #1;
        chk("rx_off reset", 8'h01, {7'h00, rx_off});
        rd(6'h01);
        chk("command reset", 8'h20, got);
        wr(6'h00, 8'hFF);
        rd(6'h00);
        chk("reserved zero", 8'h00, got);
        // unmapped offsets must not disturb the command register
        for (int i = 0; i < 4; i++) begin
            d = 8'(next_rand());
            wr(6'h02 + 6'(d % 62), 8'h00);
            rd(6'h01);
            chk("command kept", 8'h20, got);
        end
        // every command code, random reserved and receiver bits
        for (int c = 0; c < 16; c++) begin
            d = 8'(next_rand());
            d = {d[7:5], 1'b0, 4'(c)};
            ec = exp_code(c);
            wr(6'h01, d);
            chk("cmd_code", {4'h0, ec}, {4'h0, cmd_code});
            chk("cmd_start", {7'h00, ec != 0}, {7'h00, cmd_start});
            chk("flag", {7'h00, c != 0 && !known[c]}, {7'h00, done_flag});
            chk("rx_off", {7'h00, d[5]}, {7'h00, rx_off});
            rd(6'h01);
            chk("readback", {2'b00, d[5], 1'b0, ec}, got);
            if (ec != 0) begin
                fin();
                chk("finish code", 8'h00, {4'h0, cmd_code});
                chk("finish flag", 8'h01, {7'h00, done_flag});
            end
            clr();
        end
        // host aborting with idle raises no flag
        wr(6'h01, 8'h05);
        wr(6'h01, 8'h00);
        chk("abort code", 8'h00, {4'h0, cmd_code});
        chk("abort flag", 8'h00, {7'h00, done_flag});
        // a finish while idle is ignored
        fin();
        chk("idle finish", 8'h00, {7'h00, done_flag});
        // the flag set beats its clear in the same cycle
        wr(6'h01, 8'h23);
        @(posedge mclk);
        cmd_finish    <= 1'b1;
        done_flag_clr <= 1'b1;
        @(posedge mclk);
        cmd_finish    <= 1'b0;
        done_flag_clr <= 1'b0;
        #1;
        chk("set beats clear", 8'h01, {7'h00, done_flag});
        chk("set beats clear code", 8'h00, {4'h0, cmd_code});
        clr();
        // sleep refused while software reinit runs
        wr(6'h01, 8'h1F);
        chk("sleep refused", 8'h00, {7'h00, sleep_active});
        rd(6'h01);
        chk("reinit read", 8'h0F, got);
        wr(6'h01, 8'h10);
        chk("sleep refused 2", 8'h00, {7'h00, sleep_active});
        clr();
        // sleep, then wake and poll until ready
        wr(6'h01, 8'h30);
        chk("sleep", 8'h01, {7'h00, sleep_active});
        rd(6'h01);
        chk("sleep read", 8'h30, got);
        wr(6'h01, 8'h20);
        rd(6'h01);
        chk("waking read", 8'h30, got);
        n = 0;
        while (got[4] !== 1'b0 && n < 200) begin
            rd(6'h01);
            n++;
        end
        chk("wake timeout", 8'h01, {7'h00, n < 200});
        chk("wake length", 8'h01, {7'h00, n >= `WAKE_CYCLES / 2 - 2});
        chk("ready read", 8'h20, got);
        chk("awake", 8'h00, {7'h00, sleep_active});
        // reset while asleep must bring back the reset value
        wr(6'h01, 8'h10);
        chk("sleep again", 8'h01, {7'h00, sleep_active});
        @(posedge mclk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge mclk);
        sys_rst <= 1'b0;
        #1;
        chk("rx_off re-reset", 8'h01, {7'h00, rx_off});
        chk("sleep re-reset", 8'h00, {7'h00, sleep_active});
        rd(6'h01);
        chk("command re-reset", 8'h20, got);
        end_sim();
    end

endmodule
`default_nettype wire
